// [cmr_params.svh]
`ifndef CMR_PARAMS_SVH
`define CMR_PARAMS_SVH

// ----------------------------------------
// Sizes
// ----------------------------------------
`define CMR_NCH 3
`define CMR_NBUF 16
`define CMR_TXF_DEPTH 4
`define CMR_ID_W 11

// ----------------------------------------
// Register byte addresses
// ----------------------------------------
`define CMR_A_GEN_CFG 8'h00
`define CMR_A_RXBOX_CNT 8'h04
`define CMR_A_RXFIFO_DEPTH 8'h08
`define CMR_A_FILT_CH0 8'h0C
`define CMR_A_FILT_CH1 8'h10
`define CMR_A_FILT_CH2 8'h14
`define CMR_A_TXFIFO_CFG 8'h18
`define CMR_A_TXQ_CFG 8'h1C
`define CMR_A_TXBUF_SEL 8'h20
`define CMR_A_TXBUF_CTRL 8'h24
`define CMR_A_TXFIFO_PUSH 8'h28
`define CMR_A_OBJ_SEL 8'h2C
`define CMR_A_OBJ_ADDR 8'h30
`define CMR_A_STATUS 8'h34
`define CMR_A_TX_PEND 8'h38

// ----------------------------------------
// Fields
// ----------------------------------------
`define CMR_F_GEN 1:0
`define CMR_F_JOIN 2
`define CMR_F_BOX_PL 5:3
`define CMR_F_FIFO_PL 8:6
`define CMR_F_CNT 7:0
`define CMR_F_FILT 8:0
`define CMR_F_BUF 3:0
`define CMR_F_EN 4
`define CMR_F_ID 10:0
`define CMR_F_PL 22:16
`define CMR_F_REQ 31
`define CMR_F_OBJ 8:0

// ----------------------------------------
// Memory layout
// ----------------------------------------
`define CMR_HDR_BYTES 7'h0C
`define CMR_FILT_ENTRY 16'h0010
`define CMR_FLEX_BASE 16'h2400
`define CMR_FLEX_LIMIT 16'h1500
`define CMR_GEN2_PL_MAX 3'h3

// ----------------------------------------
// Filter pool per generation
// ----------------------------------------
`define CMR_FPC_G2 10'h040
`define CMR_FPC_G3 10'h080
`define CMR_FPC_G4 10'h0C0
`define CMR_FMAX_G2 10'h07F
`define CMR_FMAX_G3 10'h0FF
`define CMR_FMAX_G4 10'h180

// ----------------------------------------
// Transmit buffers
// ----------------------------------------
`define CMR_G2_BUF_CAP 7'h14
`define CMR_JOIN2_CAP 7'h30
`define CMR_FULL_CAP 7'h40
`define CMR_JOIN_BASE0 4'h0
`define CMR_JOIN_BASE1 4'h3
`define CMR_JOIN_LAST 4'h5

`endif

// [cmr_pkg.sv]
package cmr_pkg;
   typedef enum logic [1:0] {
      CMR_GEN2 = 2'b00,
      CMR_GEN3 = 2'b01,
      CMR_GEN4 = 2'b10,
      CMR_GEN_RSV = 2'b11
   } cmr_gen_t;
endpackage : cmr_pkg

// [cmr_msg_map.sv]
// The address-and-strobe port and the register addresses are this design's own decisions.
`timescale 1ns/1ps
`default_nettype none
`include "cmr_params.svh"

// Contract
// - Filter area and reception area never overlap
// - One shared filter pool, bounded total
// - Filter counts set per channel independently
// - Gen4 pool 192 per channel, 384 max
// - Box takes 12+d, d per generation
// - FIFO element takes 12+d bytes
// - Transmit FIFO fits any transmit buffer
// - Gen2 buffer 20 bytes unless joined or used by the FIFO
// - Joined followers are payload storage only
// - Joining buffers 0-5, base 0 or 3
// - Group size from payload: 48, 64
// - Gen3 and later buffers hold 64 bytes
// - FIFO reuses one buffer, 64 bytes
// - Gen2 queue 20 bytes, depth members
// - Queue by priority, FIFO in order
// - All candidates arbitrate for lowest id
module cmr_msg_map
   import cmr_pkg::*;
(
   // Clock and reset
   input wire logic core_clk,
   input wire logic reset,
   // Register port
   input wire logic [7:0] reg_addr,
   input wire logic [31:0] reg_wdata,
   input wire logic reg_wr,
   input wire logic reg_rd,
   output logic [31:0] reg_rdata,
   // Transmit selection to protocol core
   output logic tx_sel_valid,
   output logic [3:0] tx_sel_buf,
   output logic [10:0] tx_sel_id,
   output logic [6:0] tx_sel_len,
   output logic tx_sel_fifo,
   input wire logic tx_done
);

   // ----------------------------------------
   // Helpers
   // ----------------------------------------
   function automatic logic [6:0] cmr_pl_bytes(input logic [2:0] code);
      logic [6:0] b;
      b = 7'h08;
      unique case (code)
         3'h0: b = 7'h08;
         3'h1: b = 7'h0C;
         3'h2: b = 7'h10;
         3'h3: b = 7'h14;
         3'h4: b = 7'h18;
         3'h5: b = 7'h20;
         3'h6: b = 7'h30;
         3'h7: b = 7'h40;
      endcase
      return b;
   endfunction : cmr_pl_bytes

   function automatic logic [15:0] cmr_span(input logic [8:0] n,
                                            input logic [6:0] sz);
      logic [15:0] p;
      p = 16'({7'h00, n} * {9'h000, sz});
      return p;
   endfunction : cmr_span

   // ----------------------------------------
   // Registers
   // ----------------------------------------
   cmr_gen_t gen_ff;
   logic join_ff;
   logic [2:0] box_pl_ff;
   logic [2:0] fifo_pl_ff;
   logic [7:0] box_cnt_ff;
   logic [7:0] rxf_depth_ff;
   logic [8:0] filt_ff [`CMR_NCH];
   logic txf_en_ff;
   logic [3:0] txf_buf_ff;
   logic txq_en_ff;
   logic [3:0] txq_first_ff;
   logic [3:0] buf_sel_ff;
   logic [8:0] obj_sel_ff;
   logic [`CMR_ID_W-1:0] id_ff [`CMR_NBUF];
   logic [6:0] pl_ff [`CMR_NBUF];
   logic [`CMR_NBUF-1:0] req_ff;
   logic [`CMR_ID_W-1:0] txf_mem_ff [`CMR_TXF_DEPTH];
   logic [6:0] txf_len_ff [`CMR_TXF_DEPTH];
   logic [1:0] txf_rd_ff;
   logic [1:0] txf_wr_ff;
   logic [2:0] txf_cnt_ff;
   logic [31:0] rdata_ff;
   logic sel_valid_ff;
   logic [3:0] sel_buf_ff;
   logic [10:0] sel_id_ff;
   logic [6:0] sel_len_ff;
   logic sel_fifo_ff;

   // ----------------------------------------
   // Address decode
   // ----------------------------------------
   wire logic wr_gen = reg_wr && (reg_addr == `CMR_A_GEN_CFG);
   wire logic wr_box = reg_wr && (reg_addr == `CMR_A_RXBOX_CNT);
   wire logic wr_rxf = reg_wr && (reg_addr == `CMR_A_RXFIFO_DEPTH);
   wire logic wr_f0 = reg_wr && (reg_addr == `CMR_A_FILT_CH0);
   wire logic wr_f1 = reg_wr && (reg_addr == `CMR_A_FILT_CH1);
   wire logic wr_f2 = reg_wr && (reg_addr == `CMR_A_FILT_CH2);
   wire logic wr_txf = reg_wr && (reg_addr == `CMR_A_TXFIFO_CFG);
   wire logic wr_txq = reg_wr && (reg_addr == `CMR_A_TXQ_CFG);
   wire logic wr_bsel = reg_wr && (reg_addr == `CMR_A_TXBUF_SEL);
   wire logic wr_ctrl = reg_wr && (reg_addr == `CMR_A_TXBUF_CTRL);
   wire logic wr_push = reg_wr && (reg_addr == `CMR_A_TXFIFO_PUSH);
   wire logic wr_osel = reg_wr && (reg_addr == `CMR_A_OBJ_SEL);

   // ----------------------------------------
   // Filter pool
   // ----------------------------------------
   wire logic is_g2 = (gen_ff == CMR_GEN2);
   wire logic is_g3 = (gen_ff == CMR_GEN3);
   wire logic [9:0] f_per_ch = is_g2 ? `CMR_FPC_G2 :
                               is_g3 ? `CMR_FPC_G3 : `CMR_FPC_G4;
   wire logic [9:0] f_max_ch = is_g2 ? `CMR_FMAX_G2 :
                               is_g3 ? `CMR_FMAX_G3 : `CMR_FMAX_G4;
   wire logic [11:0] f_pool = 12'(f_per_ch * 2'(`CMR_NCH));
   wire logic [11:0] f_total = 12'(filt_ff[0]) + 12'(filt_ff[1]) +
                               12'(filt_ff[2]);
   wire logic f_ch_over = ({1'b0, filt_ff[0]} > f_max_ch) ||
                          ({1'b0, filt_ff[1]} > f_max_ch) ||
                          ({1'b0, filt_ff[2]} > f_max_ch);
   wire logic filt_err = (f_total > f_pool) || f_ch_over;

   // ----------------------------------------
   // Flexible reception area
   // ----------------------------------------
   wire logic [6:0] box_sz = `CMR_HDR_BYTES + cmr_pl_bytes(box_pl_ff);
   wire logic [6:0] elem_sz = `CMR_HDR_BYTES + cmr_pl_bytes(fifo_pl_ff);
   wire logic box_pl_err = is_g2 && (box_pl_ff > `CMR_GEN2_PL_MAX);
   wire logic [15:0] box_bytes = cmr_span({1'b0, box_cnt_ff}, box_sz);
   wire logic [15:0] elem_bytes = cmr_span({1'b0, rxf_depth_ff}, elem_sz);
   wire logic [15:0] flex_used = box_bytes + elem_bytes;
   // Limit is a software duty; only reported here
   wire logic flex_over = flex_used > `CMR_FLEX_LIMIT;
   wire logic obj_in_box = obj_sel_ff < {1'b0, box_cnt_ff};
   wire logic [8:0] obj_elem = obj_sel_ff - {1'b0, box_cnt_ff};
   // Flex area starts past the largest filter pool
   wire logic [15:0] obj_addr = `CMR_FLEX_BASE + (obj_in_box ?
      cmr_span(obj_sel_ff, box_sz) :
      box_bytes + cmr_span(obj_elem, elem_sz));

   // ----------------------------------------
   // Transmit buffer map
   // ----------------------------------------
   wire logic join_on = is_g2 && join_ff;
   wire logic [6:0] pl0 = pl_ff[`CMR_JOIN_BASE0];
   wire logic [6:0] pl3 = pl_ff[`CMR_JOIN_BASE1];
   logic [`CMR_NBUF-1:0] covered;
   logic [`CMR_NBUF-1:0] elig;
   logic [`CMR_NBUF-1:0] oversize;
   logic [6:0] cap [`CMR_NBUF];

   always_comb begin
      covered = '0;
      // Followers of a group are storage only
      covered[1] = join_on && (pl0 > `CMR_G2_BUF_CAP);
      covered[2] = join_on && (pl0 > `CMR_JOIN2_CAP);
      covered[4] = join_on && (pl3 > `CMR_G2_BUF_CAP);
      covered[5] = join_on && (pl3 > `CMR_JOIN2_CAP);
      for (int i = 0; i < `CMR_NBUF; i++) begin
         if (!is_g2) begin
            cap[i] = `CMR_FULL_CAP;
         end else if (txf_en_ff && (4'(i) == txf_buf_ff)) begin
            cap[i] = `CMR_FULL_CAP;
         end else if (txq_en_ff && (4'(i) >= txq_first_ff)) begin
            cap[i] = `CMR_G2_BUF_CAP;
         end else if (join_on && ((4'(i) == `CMR_JOIN_BASE0) ||
                      (4'(i) == `CMR_JOIN_BASE1))) begin
            cap[i] = `CMR_FULL_CAP;
         end else begin
            cap[i] = `CMR_G2_BUF_CAP;
         end
         oversize[i] = req_ff[i] && (pl_ff[i] > cap[i]);
         elig[i] = req_ff[i] && !oversize[i] && !covered[i] &&
                   !(txf_en_ff && (4'(i) == txf_buf_ff));
      end
   end

   wire logic join_bad = join_on && txq_en_ff &&
                         (txq_first_ff <= `CMR_JOIN_LAST);
   wire logic tx_cfg_err = (|oversize) || join_bad;

   // ----------------------------------------
   // Transmit arbitration
   // ----------------------------------------
   wire logic txf_head_ok = txf_en_ff && (txf_cnt_ff != 3'h0);
   logic cand_found;
   logic [3:0] cand_buf;
   logic [10:0] cand_id;
   logic [6:0] cand_len;
   logic cand_fifo;

   always_comb begin
      cand_found = txf_head_ok;
      cand_buf = txf_buf_ff;
      cand_id = txf_mem_ff[txf_rd_ff];
      cand_len = txf_len_ff[txf_rd_ff];
      cand_fifo = txf_head_ok;
      // Lowest id wins; ties go to lower buffer
      for (int i = 0; i < `CMR_NBUF; i++) begin
         if (elig[i] && (!cand_found || (id_ff[i] < cand_id) ||
             ((id_ff[i] == cand_id) && (4'(i) < cand_buf)))) begin
            cand_found = 1'b1;
            cand_buf = 4'(i);
            cand_id = id_ff[i];
            cand_len = pl_ff[i];
            cand_fifo = 1'b0;
         end
      end
   end

   wire logic done_fifo = tx_done && sel_valid_ff && sel_fifo_ff;
   wire logic done_buf = tx_done && sel_valid_ff && !sel_fifo_ff;
   wire logic txf_push = wr_push && (txf_cnt_ff != 3'(`CMR_TXF_DEPTH));
   wire logic [2:0] nxt_txf_cnt = txf_cnt_ff + {2'b00, txf_push} -
                                  {2'b00, done_fifo};
   logic [`CMR_NBUF-1:0] nxt_req;

   always_comb begin
      for (int i = 0; i < `CMR_NBUF; i++) begin
         if (wr_ctrl && (buf_sel_ff == 4'(i))) begin
            nxt_req[i] = reg_wdata[`CMR_F_REQ];
         end else if (done_buf && (sel_buf_ff == 4'(i))) begin
            nxt_req[i] = 1'b0;
         end else begin
            nxt_req[i] = req_ff[i];
         end
      end
   end

   // ----------------------------------------
   // Read mux
   // ----------------------------------------
   logic [31:0] rd_mux;

   always_comb begin
      rd_mux = 32'h0000_0000;
      unique case (reg_addr)
         `CMR_A_GEN_CFG: rd_mux = {23'h00_0000, fifo_pl_ff, box_pl_ff,
                                   join_ff, gen_ff};
         `CMR_A_RXBOX_CNT: rd_mux = {24'h00_0000, box_cnt_ff};
         `CMR_A_RXFIFO_DEPTH: rd_mux = {24'h00_0000, rxf_depth_ff};
         `CMR_A_FILT_CH0: rd_mux = {23'h00_0000, filt_ff[0]};
         `CMR_A_FILT_CH1: rd_mux = {23'h00_0000, filt_ff[1]};
         `CMR_A_FILT_CH2: rd_mux = {23'h00_0000, filt_ff[2]};
         `CMR_A_TXFIFO_CFG: rd_mux = {27'h000_0000, txf_en_ff, txf_buf_ff};
         `CMR_A_TXQ_CFG: rd_mux = {27'h000_0000, txq_en_ff, txq_first_ff};
         `CMR_A_TXBUF_SEL: rd_mux = {28'h000_0000, buf_sel_ff};
         `CMR_A_TXBUF_CTRL: rd_mux = {req_ff[buf_sel_ff], 8'h00,
                                      pl_ff[buf_sel_ff], 5'h00,
                                      id_ff[buf_sel_ff]};
         `CMR_A_TXFIFO_PUSH: rd_mux = {29'h0000_0000, txf_cnt_ff};
         `CMR_A_OBJ_SEL: rd_mux = {23'h00_0000, obj_sel_ff};
         `CMR_A_OBJ_ADDR: rd_mux = {16'h0000, obj_addr};
         `CMR_A_STATUS: rd_mux = {flex_used, 11'h000, box_pl_err,
                                  txf_cnt_ff == 3'(`CMR_TXF_DEPTH),
                                  tx_cfg_err, flex_over, filt_err};
         `CMR_A_TX_PEND: rd_mux = {16'h0000, req_ff};
         default: rd_mux = 32'h0000_0000;
      endcase
   end

   // ----------------------------------------
   // State
   // ----------------------------------------
   always_ff @(posedge core_clk) begin
      if (reset) begin
         gen_ff <= CMR_GEN2;
         join_ff <= 1'b0;
         box_pl_ff <= 3'h0;
         fifo_pl_ff <= 3'h0;
         box_cnt_ff <= 8'h00;
         rxf_depth_ff <= 8'h00;
         txf_en_ff <= 1'b0;
         txf_buf_ff <= 4'h0;
         txq_en_ff <= 1'b0;
         txq_first_ff <= 4'h0;
         buf_sel_ff <= 4'h0;
         obj_sel_ff <= 9'h000;
      end else begin
         if (wr_gen) begin
            gen_ff <= cmr_gen_t'(reg_wdata[`CMR_F_GEN]);
            join_ff <= reg_wdata[`CMR_F_JOIN];
            box_pl_ff <= reg_wdata[`CMR_F_BOX_PL];
            fifo_pl_ff <= reg_wdata[`CMR_F_FIFO_PL];
         end
         if (wr_box) box_cnt_ff <= reg_wdata[`CMR_F_CNT];
         if (wr_rxf) rxf_depth_ff <= reg_wdata[`CMR_F_CNT];
         if (wr_txf) begin
            txf_en_ff <= reg_wdata[`CMR_F_EN];
            txf_buf_ff <= reg_wdata[`CMR_F_BUF];
         end
         if (wr_txq) begin
            txq_en_ff <= reg_wdata[`CMR_F_EN];
            txq_first_ff <= reg_wdata[`CMR_F_BUF];
         end
         if (wr_bsel) buf_sel_ff <= reg_wdata[`CMR_F_BUF];
         if (wr_osel) obj_sel_ff <= reg_wdata[`CMR_F_OBJ];
      end
   end

   always_ff @(posedge core_clk) begin
      if (reset) begin
         for (int c = 0; c < `CMR_NCH; c++) filt_ff[c] <= 9'h000;
      end else begin
         if (wr_f0) filt_ff[0] <= reg_wdata[`CMR_F_FILT];
         if (wr_f1) filt_ff[1] <= reg_wdata[`CMR_F_FILT];
         if (wr_f2) filt_ff[2] <= reg_wdata[`CMR_F_FILT];
      end
   end

   always_ff @(posedge core_clk) begin
      if (reset) begin
         req_ff <= '0;
         for (int i = 0; i < `CMR_NBUF; i++) begin
            id_ff[i] <= 11'h000;
            pl_ff[i] <= 7'h00;
         end
      end else begin
         req_ff <= nxt_req;
         if (wr_ctrl) begin
            id_ff[buf_sel_ff] <= reg_wdata[`CMR_F_ID];
            pl_ff[buf_sel_ff] <= reg_wdata[`CMR_F_PL];
         end
      end
   end

   always_ff @(posedge core_clk) begin
      if (reset) begin
         txf_rd_ff <= 2'h0;
         txf_wr_ff <= 2'h0;
         txf_cnt_ff <= 3'h0;
         for (int j = 0; j < `CMR_TXF_DEPTH; j++) begin
            txf_mem_ff[j] <= 11'h000;
            txf_len_ff[j] <= 7'h00;
         end
      end else begin
         if (txf_push) begin
            txf_mem_ff[txf_wr_ff] <= reg_wdata[`CMR_F_ID];
            txf_len_ff[txf_wr_ff] <= reg_wdata[`CMR_F_PL];
            txf_wr_ff <= txf_wr_ff + 2'h1;
         end
         if (done_fifo) txf_rd_ff <= txf_rd_ff + 2'h1;
         txf_cnt_ff <= nxt_txf_cnt;
      end
   end

   always_ff @(posedge core_clk) begin
      if (reset) begin
         rdata_ff <= 32'h0000_0000;
         sel_valid_ff <= 1'b0;
         sel_buf_ff <= 4'h0;
         sel_id_ff <= 11'h000;
         sel_len_ff <= 7'h00;
         sel_fifo_ff <= 1'b0;
      end else begin
         rdata_ff <= reg_rd ? rd_mux : 32'h0000_0000;
         // Withdraw offer for one cycle after a completion
         sel_valid_ff <= cand_found && !tx_done;
         sel_buf_ff <= cand_buf;
         sel_id_ff <= cand_id;
         sel_len_ff <= cand_len;
         sel_fifo_ff <= cand_fifo;
      end
   end

   assign reg_rdata = rdata_ff;
   assign tx_sel_valid = sel_valid_ff;
   assign tx_sel_buf = sel_buf_ff;
   assign tx_sel_id = sel_id_ff;
   assign tx_sel_len = sel_len_ff;
   assign tx_sel_fifo = sel_fifo_ff;

endmodule : cmr_msg_map
`default_nettype wire

// [cmr_msg_map_monitor.sv]
`timescale 1ns/1ps
`default_nettype none
module cmr_msg_map_monitor (
   // Clock and reset
   input wire logic core_clk,
   input wire logic reset,
   // Register port
   input wire logic [7:0] reg_addr,
   input wire logic [31:0] reg_wdata,
   input wire logic reg_wr,
   input wire logic reg_rd,
   input wire logic [31:0] reg_rdata,
   // Transmit selection
   input wire logic tx_sel_valid,
   input wire logic [3:0] tx_sel_buf,
   input wire logic [10:0] tx_sel_id,
   input wire logic [6:0] tx_sel_len,
   input wire logic tx_sel_fifo,
   input wire logic tx_done
);
   logic [8:0] cfg_ff;
   logic [3:0] fbuf_ff;
   logic [1:0] age_ff;
   wire cfg_hit = reg_wr && reg_addr == 8'h00;
   wire fifo_hit = reg_wr && reg_addr == 8'h18;
   wire g2 = cfg_ff[1:0] == 2'b00 && age_ff == 2'h3 && !tx_sel_fifo;

   // Shadow of config, aged so selection lag settles
   always_ff @(posedge core_clk) begin
      if (reset) begin
         cfg_ff <= 9'h000;
         fbuf_ff <= 4'h0;
         age_ff <= 2'h0;
      end else begin
         if (cfg_hit)
            cfg_ff <= reg_wdata[8:0];
         if (fifo_hit)
            fbuf_ff <= reg_wdata[3:0];
         if (cfg_hit || fifo_hit)
            age_ff <= 2'h0;
         else if (age_ff != 2'h3)
            age_ff <= age_ff + 2'h1;
      end
   end

   default clocking cb @(posedge core_clk); endclocking
   default disable iff (reset);

   rd_idle_a:
      assert property (!$past(reg_rd) |-> reg_rdata == 32'h0000_0000)
      else $error("read data not zero outside answer cycle");
   sent_drop_a:
      assert property (tx_done && tx_sel_valid |=> !tx_sel_valid)
      else $error("offer kept after send");
   len_cap_a:
      assert property (tx_sel_valid |-> tx_sel_len <= 7'h40)
      else $error("offered payload above 64");
   g2_single_a:
      assert property (g2 && tx_sel_valid && tx_sel_buf != 4'h0
         && tx_sel_buf != 4'h3 |-> tx_sel_len <= 7'h14)
      else $error("unjoinable buffer offered above 20");
   g2_join_a:
      assert property (g2 && tx_sel_valid && tx_sel_len > 7'h14 |-> cfg_ff[2])
      else $error("large payload offered without joining");
   fifo_buf_a:
      assert property (tx_sel_valid && tx_sel_fifo && age_ff == 2'h3
         |-> tx_sel_buf == fbuf_ff)
      else $error("fifo offered on wrong buffer");
   box_flag_a:
      assert property ($past(reg_rd) && $past(reg_addr) == 8'h34
         |-> reg_rdata[4] == ($past(cfg_ff[1:0]) == 2'b00
         && $past(cfg_ff[5:3]) > 3'h3))
      else $error("box payload flag wrong");
   reset_quiet_a:
      assert property ($past(reset) |-> !tx_sel_valid)
      else $error("offer right after reset");
endmodule : cmr_msg_map_monitor

bind cmr_msg_map cmr_msg_map_monitor mon (.core_clk(core_clk),
   .reset(reset), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
   .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
   .tx_sel_valid(tx_sel_valid), .tx_sel_buf(tx_sel_buf),
   .tx_sel_id(tx_sel_id), .tx_sel_len(tx_sel_len),
   .tx_sel_fifo(tx_sel_fifo), .tx_done(tx_done));
`default_nettype wire

// [cmr_core_model.sv]
`timescale 1ns/1ps
`default_nettype none
module cmr_core_model (
   // Clock and reset
   input wire logic core_clk,
   input wire logic reset,
   // Offered candidate
   input wire logic tx_sel_valid,
   output logic tx_done,
   // Pacing
   input wire logic go,
   input wire logic [3:0] delay
);
   logic [3:0] wait_ff;
   wire idle = reset || !tx_sel_valid || tx_done || !go;

   // Send the offered head after the set delay
   always_ff @(posedge core_clk) begin
      if (idle) begin
         wait_ff <= 4'h0;
         tx_done <= 1'b0;
      end else if (wait_ff == delay) begin
         tx_done <= 1'b1;
      end else begin
         wait_ff <= wait_ff + 4'h1;
      end
   end
endmodule : cmr_core_model
`default_nettype wire

// [cmr_msg_map_test.sv]
`timescale 1ns/1ps
`default_nettype none
module cmr_msg_map_test;
   logic core_clk, reset, reg_wr, reg_rd, tx_sel_valid, tx_sel_fifo;
   logic tx_done, go;
   logic [3:0] delay, tx_sel_buf;
   logic [7:0] reg_addr;
   logic [31:0] reg_wdata, reg_rdata, rv;
   logic [10:0] tx_sel_id;
   logic [6:0] tx_sel_len;
   logic [22:0] expq [$];
   int fails, n_tests;
   int sz [8] = '{8, 12, 16, 20, 24, 32, 48, 64};

   cmr_msg_map dut (.core_clk(core_clk), .reset(reset),
      .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
      .reg_rd(reg_rd), .reg_rdata(reg_rdata),
      .tx_sel_valid(tx_sel_valid), .tx_sel_buf(tx_sel_buf),
      .tx_sel_id(tx_sel_id), .tx_sel_len(tx_sel_len),
      .tx_sel_fifo(tx_sel_fifo), .tx_done(tx_done));
   cmr_core_model core (.core_clk(core_clk), .reset(reset),
      .tx_sel_valid(tx_sel_valid), .tx_done(tx_done), .go(go),
      .delay(delay));

   // ----------------------------------------
   // Helpers
   // ----------------------------------------
   task summarize;
      $display("comparisons %0d mismatches %0d", n_tests, fails);
      if (fails == 0 && n_tests > 0)
         $display("Finished cleanly");
      else
         $display("Finished with errors");
      $finish;
   endtask : summarize

   task chk(input string what, input logic [31:0] seen, exp);
      n_tests++;
      if (seen !== exp) begin
         fails++;
         $display("mismatch %s expected %h seen %h", what, exp, seen);
      end
   endtask : chk

   task wr(input logic [7:0] a, input logic [31:0] d);
      @(posedge core_clk);
      reg_addr <= a;
      reg_wdata <= d;
      reg_wr <= 1'b1;
      @(posedge core_clk);
      reg_wr <= 1'b0;
   endtask : wr

   task rd(input logic [7:0] a);
      @(posedge core_clk);
      reg_addr <= a;
      reg_rd <= 1'b1;
      @(posedge core_clk);
      reg_rd <= 1'b0;
      @(negedge core_clk);
      rv = reg_rdata;
   endtask : rd

   task rchk(input string what, input logic [7:0] a, input logic [31:0] e);
      rd(a);
      chk(what, rv, e);
   endtask : rchk

   task load(input logic [3:0] b, input logic [10:0] id, input logic [6:0] n);
      wr(8'h20, {28'h000_0000, b});
      wr(8'h24, {1'b1, 8'h00, n, 5'h00, id});
   endtask : load

   task send_all;
      int w;
      @(posedge core_clk);
      go <= 1'b1;
      foreach (expq[i]) begin
         w = 0;
         do begin
            @(negedge core_clk);
            w++;
         end while (!(tx_done && tx_sel_valid) && w < 50);
         if (!(tx_done && tx_sel_valid)) begin
            fails++;
            summarize();
         end
         chk("frame", {9'h000, tx_sel_fifo, tx_sel_buf, tx_sel_len, tx_sel_id},
            {9'h000, expq[i]});
         @(posedge core_clk);
      end
      go <= 1'b0;
   endtask : send_all

   task filt(input logic [1:0] g, input logic [8:0] a, b, c, input logic e);
      wr(8'h00, {30'h0000_0000, g});
      wr(8'h0C, {23'h00_0000, a});
      wr(8'h10, {23'h00_0000, b});
      wr(8'h14, {23'h00_0000, c});
      rd(8'h34);
      chk("filter error", {31'h0, rv[0]}, {31'h0, e});
   endtask : filt

   // ----------------------------------------
   // Scenarios
   // ----------------------------------------
   task t_regs;
      rchk("gen cfg", 8'h00, 32'h0000_0000);
      rchk("status", 8'h34, 32'h0000_0000);
      wr(8'h3C, 32'hFFFF_FFFF);
      rchk("unmapped", 8'h3C, 32'h0000_0000);
      wr(8'h10, 32'hFFFF_FFFF);
      rchk("filter count", 8'h10, 32'h0000_01FF);
      $display("done t_regs");
   endtask : t_regs

   task t_filter;
      filt(2'h2, 9'h180, 9'h000, 9'h000, 1'b0);
      filt(2'h2, 9'h181, 9'h000, 9'h000, 1'b1);
      filt(2'h2, 9'h180, 9'h0C0, 9'h000, 1'b0);
      filt(2'h2, 9'h180, 9'h0C0, 9'h001, 1'b1);
      filt(2'h3, 9'h180, 9'h0C0, 9'h000, 1'b0);
      filt(2'h0, 9'h07F, 9'h041, 9'h000, 1'b0);
      filt(2'h0, 9'h080, 9'h000, 9'h000, 1'b1);
      filt(2'h0, 9'h07F, 9'h041, 9'h001, 1'b1);
      filt(2'h1, 9'h100, 9'h000, 9'h000, 1'b1);
      filt(2'h1, 9'h0FF, 9'h081, 9'h000, 1'b0);
      $display("done t_filter");
   endtask : t_filter

   task t_flex;
      wr(8'h04, 32'h0000_0001);
      wr(8'h08, 32'h0000_0003);
      for (int c = 0; c < 8; c++) begin
         wr(8'h00, 32'h0000_0001 | (c << 3) | (c << 6));
         wr(8'h2C, 32'h0000_0002);
         rchk("object addr", 8'h30, 32'h2400 + 2 * (12 + sz[c]));
         rchk("flex used", 8'h34, (4 * (12 + sz[c])) << 16);
      end
      wr(8'h00, 32'h0000_0079);
      wr(8'h04, 32'h0000_0002);
      wr(8'h2C, 32'h0000_0003);
      rchk("mixed addr", 8'h30, 32'h0000_24B0);
      wr(8'h04, 32'h0000_0000);
      wr(8'h00, 32'h0000_01C1);
      wr(8'h08, 32'h0000_0046);
      rd(8'h34);
      chk("flex at limit", {31'h0000_0000, rv[1]}, 32'h0000_0000);
      wr(8'h08, 32'h0000_0047);
      rd(8'h34);
      chk("flex over", {31'h0000_0000, rv[1]}, 32'h0000_0001);
      wr(8'h08, 32'h0000_0000);
      wr(8'h00, 32'h0000_0020);
      rd(8'h34);
      chk("gen2 box code", {31'h0000_0000, rv[4]}, 32'h0000_0001);
      wr(8'h00, 32'h0000_0018);
      rd(8'h34);
      chk("gen2 box ok", {31'h0000_0000, rv[4]}, 32'h0000_0000);
      $display("done t_flex");
   endtask : t_flex

   task t_join;
      wr(8'h00, 32'h0000_0004);
      load(4'h0, 11'h050, 7'h30);
      load(4'h1, 11'h010, 7'h08);
      load(4'h2, 11'h070, 7'h14);
      load(4'h3, 11'h060, 7'h40);
      load(4'h7, 11'h005, 7'h15);
      rd(8'h34);
      chk("buf over cap", {31'h0000_0000, rv[2]}, 32'h0000_0001);
      delay <= 4'h0;
      expq = '{{1'b0, 4'h0, 7'h30, 11'h050}, {1'b0, 4'h3, 7'h40, 11'h060},
         {1'b0, 4'h2, 7'h14, 11'h070}};
      send_all();
      rchk("pending", 8'h38, 32'h0000_0082);
      wr(8'h00, 32'h0000_0001);
      load(4'h5, 11'h007, 7'h40);
      expq = '{{1'b0, 4'h7, 7'h15, 11'h005}, {1'b0, 4'h5, 7'h40, 11'h007},
         {1'b0, 4'h1, 7'h08, 11'h010}};
      send_all();
      wr(8'h00, 32'h0000_0000);
      load(4'h0, 11'h050, 7'h30);
      rd(8'h34);
      chk("join off", {31'h0000_0000, rv[2]}, 32'h0000_0001);
      wr(8'h24, 32'h0000_0000);
      $display("done t_join");
   endtask : t_join

   task t_queue;
      wr(8'h18, 32'h0000_0016);
      wr(8'h1C, 32'h0000_0018);
      wr(8'h28, 32'h0040_0030);
      wr(8'h28, 32'h0008_0008);
      rchk("fifo count", 8'h28, 32'h0000_0002);
      load(4'h9, 11'h020, 7'h14);
      load(4'h8, 11'h040, 7'h14);
      load(4'hA, 11'h040, 7'h0C);
      load(4'h7, 11'h035, 7'h10);
      load(4'hB, 11'h001, 7'h15);
      delay <= 4'h3;
      expq = '{{1'b0, 4'h9, 7'h14, 11'h020}, {1'b1, 4'h6, 7'h40, 11'h030},
         {1'b1, 4'h6, 7'h08, 11'h008}, {1'b0, 4'h7, 7'h10, 11'h035},
         {1'b0, 4'h8, 7'h14, 11'h040}, {1'b0, 4'hA, 7'h0C, 11'h040}};
      send_all();
      rchk("queue refused", 8'h38, 32'h0000_0800);
      for (int i = 0; i < 5; i++)
         wr(8'h28, 32'h0008_0100 + i);
      rchk("fifo full", 8'h28, 32'h0000_0004);
      rd(8'h34);
      chk("fifo full flag", {31'h0, rv[3]}, 32'h0000_0001);
      wr(8'h20, 32'h0000_000B);
      wr(8'h24, 32'h0000_0000);
      wr(8'h00, 32'h0000_0004);
      rd(8'h34);
      chk("join clear", {31'h0, rv[2]}, 32'h0000_0000);
      wr(8'h1C, 32'h0000_0013);
      rd(8'h34);
      chk("join in queue", {31'h0, rv[2]}, 32'h0000_0001);
      $display("done t_queue");
   endtask : t_queue

   // ----------------------------------------
   // Run
   // ----------------------------------------
   initial begin
      core_clk = 1'b0;
      forever #25 core_clk = ~core_clk;
   end

   initial begin
      reset = 1'b1;
      reg_wr = 1'b0;
      reg_rd = 1'b0;
      reg_addr = 8'h00;
      reg_wdata = 32'h0000_0000;
      go = 1'b0;
      delay = 4'h0;
      fails = 0;
      n_tests = 0;
      repeat (3) @(posedge core_clk);
      reset <= 1'b0;
      t_regs();
      t_filter();
      t_flex();
      t_join();
      t_queue();
      summarize();
   end
endmodule : cmr_msg_map_test
`default_nettype wire
